/* pftc_pkg.sv */
// constants and types for the pasid translation fault checker
package pftc_pkg;

  // header address type of a translation request
  localparam logic [1:0] AT_TRANSLATION = 2'h1;

  // field widths
  localparam int PASID_W  = 20;
  localparam int REASON_W = 8;
  localparam int STATUS_W = 3;

  // fault reason codes
  localparam logic [7:0] FR_ROOT_ABSENT    = 8'h01;
  localparam logic [7:0] FR_CTX_ABSENT     = 8'h02;
  localparam logic [7:0] FR_CTX_PROGRAM    = 8'h03;
  localparam logic [7:0] FR_SL_FETCH       = 8'h07;
  localparam logic [7:0] FR_ROOT_FETCH     = 8'h08;
  localparam logic [7:0] FR_TT_BLOCK       = 8'h0d;
  localparam logic [7:0] FR_TAG_DISABLED   = 8'h10;
  localparam logic [7:0] FR_TAG_RANGE      = 8'h11;
  localparam logic [7:0] FR_EXEC_DENIED    = 8'h19;
  localparam logic [7:0] FR_SUPER_DENIED   = 8'h1a;
  localparam logic [7:0] FR_ROOT_TYPE      = 8'h1b;
  localparam logic [7:0] FR_NONE           = 8'h00;

  // translation completion status codes
  localparam logic [2:0] CPL_SUCCESS = 3'h0;
  localparam logic [2:0] CPL_UR      = 3'h1;
  localparam logic [2:0] CPL_CA      = 3'h4;

  // translation types that allow requests with pasid
  localparam logic [2:0] TT_PASID_A = 3'h1;
  localparam logic [2:0] TT_PASID_B = 3'h5;
  localparam logic [2:0] TT_PASID_C = 3'h7;

  // implementation support masks, one bit per encoding
  localparam logic [7:0] TT_SUPPORTED = 8'ha2;
  localparam logic [7:0] GW_SUPPORTED = 8'h04;

  // table size: entries are two to the power (size + offset)
  localparam int TAG_SIZE_OFFSET = 5;

  // fault class handed from the walker to the encoder
  typedef enum logic [3:0] {
    FC_NONE, FC_ROOT_TYPE, FC_ROOT_FETCH, FC_ROOT_ABSENT,
    FC_CTX_ABSENT, FC_TT_BLOCK, FC_CTX_PROGRAM, FC_TAG_DISABLED,
    FC_TAG_RANGE, FC_EXEC_DENIED, FC_TAG_FETCH, FC_SUPER_DENIED,
    FC_SL_ROOT_FETCH, FC_SL_FETCH
  } pftc_class_t;

endpackage : pftc_pkg

/* pftc_fault_if.sv */
// carrier between the table walker and the reason encoder
`timescale 1ns/1ps
interface pftc_fault_if;
  import pftc_pkg::*;
  pftc_class_t         fault_class; // which check failed
  logic [REASON_W-1:0] reason;      // fault reason code
  logic                qualified;   // qualified fault
  logic [STATUS_W-1:0] status;      // completion status
  modport walker  (output fault_class, input reason, qualified, status);
  modport encoder (input fault_class, output reason, qualified, status);
endinterface : pftc_fault_if

/* pftc_reason_map.sv */
// maps a fault class onto reason, qualification and completion status
`timescale 1ns/1ps
module pftc_reason_map (
  pftc_fault_if.encoder flt
);
  import pftc_pkg::*;

  // plain lookup; the walker registers the result
  always_comb begin
    flt.reason    = FR_NONE;
    flt.qualified = 1'b0;
    flt.status    = CPL_SUCCESS;
    case (flt.fault_class)
      // explicit blocking group answers unsupported request
      FC_ROOT_ABSENT:   begin flt.reason = FR_ROOT_ABSENT;  flt.status = CPL_UR; end
      FC_ROOT_TYPE:     begin flt.reason = FR_ROOT_TYPE;    flt.status = CPL_UR; end
      FC_CTX_ABSENT:    begin flt.reason = FR_CTX_ABSENT;   flt.status = CPL_UR; end
      FC_TT_BLOCK:      begin flt.reason = FR_TT_BLOCK;     flt.status = CPL_UR; flt.qualified = 1'b1; end
      FC_TAG_DISABLED:  begin flt.reason = FR_TAG_DISABLED; flt.status = CPL_UR; flt.qualified = 1'b1; end
      FC_TAG_RANGE:     begin flt.reason = FR_TAG_RANGE;    flt.status = CPL_UR; flt.qualified = 1'b1; end
      FC_EXEC_DENIED:   begin flt.reason = FR_EXEC_DENIED;  flt.status = CPL_UR; flt.qualified = 1'b1; end
      FC_SUPER_DENIED:  begin flt.reason = FR_SUPER_DENIED; flt.status = CPL_UR; flt.qualified = 1'b1; end
      // hardware or programming errors answer completer abort
      FC_CTX_PROGRAM:   begin flt.reason = FR_CTX_PROGRAM;  flt.status = CPL_CA; flt.qualified = 1'b1; end
      FC_SL_ROOT_FETCH: begin flt.reason = FR_CTX_PROGRAM;  flt.status = CPL_CA; flt.qualified = 1'b1; end
      FC_TAG_FETCH:     begin flt.reason = FR_CTX_PROGRAM;  flt.status = CPL_CA; flt.qualified = 1'b1; end
      FC_SL_FETCH:      begin flt.reason = FR_SL_FETCH;     flt.status = CPL_CA; flt.qualified = 1'b1; end
      FC_ROOT_FETCH:    begin flt.reason = FR_ROOT_FETCH;   flt.status = CPL_CA; flt.qualified = 1'b1; end
      default:          begin flt.reason = FR_NONE;         flt.status = CPL_SUCCESS; end
    endcase
  end

endmodule : pftc_reason_map

/* pftc_checker.sv */
// walks the translation checks of one pasid request, stage by stage
`timescale 1ns/1ps
module pftc_checker (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  // request from the translation front end
  input  wire logic                          req_valid_i,
  output logic                               req_ready_o,
  input  wire logic [1:0]                    req_at_i,
  input  wire logic                          req_has_pasid_i,
  input  wire logic [pftc_pkg::PASID_W-1:0]  req_pasid_i,
  input  wire logic                          exec_ask_bit_i,
  input  wire logic                          supervisor_level_flag_i,
  // root table base register and root entry walk
  input  wire logic                          root_table_type_i,
  input  wire logic                          root_fetch_err_i,
  input  wire logic                          root_half_sel_i,
  input  wire logic                          high_half_valid_i,
  input  wire logic                          low_half_valid_i,
  // extended context entry
  input  wire logic                          ctx_present_i,
  input  wire logic [2:0]                    ctx_ttype_i,
  input  wire logic [2:0]                    guest_width_field_i,
  input  wire logic                          process_tag_enable_i,
  input  wire logic [2:0]                    tag_table_size_i,
  input  wire logic                          exec_ask_enable_i,
  input  wire logic                          ctx_nested_i,
  // pasid table entry fetched through tag_table_pointer
  input  wire logic                          tag_addr_over_i,
  input  wire logic                          tag_fetch_err_i,
  input  wire logic                          tag_entry_present_i,
  input  wire logic                          supervisor_enable_i,
  // second-level paging walk
  input  wire logic                          sl_root_fetch_err_i,
  input  wire logic                          sl_lower_fetch_err_i,
  // verdict
  output logic                               done_o,
  output logic                               checked_o,
  output logic                               fault_o,
  output logic [pftc_pkg::REASON_W-1:0]      fault_reason_o,
  output logic                               qualified_o,
  output logic [pftc_pkg::STATUS_W-1:0]      cpl_status_o
);
  import pftc_pkg::*;

  // walk states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ROOT = 6'h02,
    ST_CTX  = 6'h04,
    ST_TAG  = 6'h08,
    ST_SL   = 6'h10,
    ST_DONE = 6'h20
  } pftc_state_t;

  pftc_state_t      state;       // current walk stage
  pftc_state_t      next_state;  // stage for the next cycle
  pftc_class_t      cls;         // fault found so far
  pftc_class_t      next_cls;    // fault found in this stage
  logic             is_pasid;    // request is one we check
  logic             take;        // request accepted this cycle

  // carrier to the reason encoder
  pftc_fault_if flt ();

  // largest pasid that the tag table can index
  function automatic logic [PASID_W-1:0] max_pasid(
    input logic [2:0] size
  );
    logic [5:0] sh;
    sh = 6'(size) + 6'(TAG_SIZE_OFFSET);
    if (sh >= 6'(PASID_W)) begin
      max_pasid = '1;
    end else begin
      max_pasid = PASID_W'((32'h1 << sh) - 32'h1);
    end
  endfunction : max_pasid

  // membership test in a one-bit-per-code support mask
  function automatic logic in_mask(
    input logic [7:0] mask,
    input logic [2:0] code
  );
    in_mask = mask[code];
  endfunction : in_mask

  // translation types that let pasid requests through
  function automatic logic tt_allows_pasid(input logic [2:0] tt);
    tt_allows_pasid = (tt == TT_PASID_A) || (tt == TT_PASID_B) ||
                      (tt == TT_PASID_C);
  endfunction : tt_allows_pasid

  // only translation requests carrying a pasid are walked
  assign is_pasid = (req_at_i == AT_TRANSLATION) &&
                    req_has_pasid_i;

  // ready only while idle; the front end holds its fields until done
  assign req_ready_o = (state == ST_IDLE);
  assign take        = ce_i && req_valid_i && req_ready_o;

  // encoder sees the class latched so far
  assign flt.fault_class = cls;

  pftc_reason_map u_map (
    .flt (flt.encoder)
  );

  // stage checks: each stage looks at its own inputs (ST_CTX and ST_TAG also at request fields, ST_SL at ctx_nested_i), and the
  // first failing check ends the walk so later stages never overwrite
  always_comb begin
    next_state = state;
    next_cls   = cls;
    case (state)
      ST_IDLE: begin
        if (req_valid_i) begin
          next_cls = FC_NONE;
          // unchecked requests are answered at once
          next_state = is_pasid ? ST_ROOT : ST_DONE;
        end
      end
      ST_ROOT: begin
        // register check precedes the fetch it steers
        if (!root_table_type_i) begin
          next_cls = FC_ROOT_TYPE;
          next_state = ST_DONE;
        end else if (root_fetch_err_i) begin
          next_cls = FC_ROOT_FETCH;
          next_state = ST_DONE;
        end else if (root_half_sel_i ? !high_half_valid_i
                                     : !low_half_valid_i) begin
          next_cls = FC_ROOT_ABSENT;
          next_state = ST_DONE;
        end else begin
          next_state = ST_CTX;
        end
      end
      ST_CTX: begin
        if (!ctx_present_i) begin
          next_cls = FC_CTX_ABSENT;
          next_state = ST_DONE;
        end else if (!tt_allows_pasid(ctx_ttype_i)) begin
          next_cls = FC_TT_BLOCK;
          next_state = ST_DONE;
        end else if (!in_mask(TT_SUPPORTED, ctx_ttype_i) ||
                     !in_mask(GW_SUPPORTED, guest_width_field_i)) begin
          next_cls = FC_CTX_PROGRAM;
          next_state = ST_DONE;
        end else if (!process_tag_enable_i) begin
          next_cls = FC_TAG_DISABLED;
          next_state = ST_DONE;
        end else if (req_pasid_i > max_pasid(tag_table_size_i)) begin
          // present and enable both known set here
          next_cls = FC_TAG_RANGE;
          next_state = ST_DONE;
        end else if (exec_ask_bit_i && !exec_ask_enable_i) begin
          next_cls = FC_EXEC_DENIED;
          next_state = ST_DONE;
        end else begin
          next_state = ST_TAG;
        end
      end
      ST_TAG: begin
        if (tag_addr_over_i || tag_fetch_err_i) begin
          next_cls = FC_TAG_FETCH;
          next_state = ST_DONE;
        end else if (tag_entry_present_i && supervisor_level_flag_i &&
                     !supervisor_enable_i) begin
          next_cls = FC_SUPER_DENIED;
          next_state = ST_DONE;
        end else begin
          next_state = ST_SL;
        end
      end
      ST_SL: begin
        // second-level root only walked when nesting is on
        if (ctx_nested_i && sl_root_fetch_err_i) begin
          next_cls = FC_SL_ROOT_FETCH;
        end else if (sl_lower_fetch_err_i) begin
          next_cls = FC_SL_FETCH;
        end
        next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        // illegal code: recover to idle with no fault
        next_state = ST_IDLE;
        next_cls   = FC_NONE;
      end
    endcase
  end

  // walk state register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      if (state == ST_IDLE && !take) begin
        state <= ST_IDLE;
      end else begin
        state <= next_state;
      end
    end
  end

  // latched fault class; one per request, never overwritten
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cls <= FC_NONE;
    end else if (ce_i) begin
      if (state == ST_IDLE && !take) begin
        cls <= cls;
      end else begin
        cls <= next_cls;
      end
    end
  end

  // whether the current request is a checked one
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      checked_o <= 1'b0;
    end else if (ce_i && take) begin
      checked_o <= is_pasid;
    end
  end

  // verdict registers: loaded when the walk reaches its end, so the
  // reason and status are stable one cycle with done and hold after
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      done_o         <= 1'b0;
      fault_o        <= 1'b0;
      fault_reason_o <= FR_NONE;
      qualified_o    <= 1'b0;
      cpl_status_o   <= CPL_SUCCESS;
    end else if (ce_i) begin
      done_o <= (state == ST_DONE);
      if (state == ST_DONE) begin
        fault_o        <= (cls != FC_NONE);
        fault_reason_o <= flt.reason;
        qualified_o    <= flt.qualified;
        cpl_status_o   <= flt.status;
      end
    end
  end

endmodule : pftc_checker

/* pftc_checker_assertions.sv */
// concurrent checks on the ports of the pasid fault checker
`timescale 1ns/1ps
module pftc_checker_sva
  import pftc_pkg::*;
(
  input wire logic                     clk_i,
  input wire logic                     rstn_i,
  input wire logic                     ce_i,
  input wire logic                     req_valid_i,
  input wire logic                     req_ready_o,
  input wire logic [1:0]               req_at_i,
  input wire logic                     req_has_pasid_i,
  input wire logic                     root_table_type_i,
  input wire logic                     root_fetch_err_i,
  input wire logic                     done_o,
  input wire logic                     checked_o,
  input wire logic                     fault_o,
  input wire logic [pftc_pkg::REASON_W-1:0] fault_reason_o,
  input wire logic                     qualified_o,
  input wire logic [pftc_pkg::STATUS_W-1:0] cpl_status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic take; // request accepted this edge
  logic pas;  // request is subject to the checks
  assign take = req_valid_i && req_ready_o && ce_i;
  assign pas = (req_at_i == AT_TRANSLATION) && req_has_pasid_i;
  AST_BUSY: assert property (take |=> !req_ready_o)
    else $error("ready stayed high after a take");
  AST_LATENCY: assert property (take |-> ##[2:6] done_o)
    else $error("no verdict after a take");
  AST_PULSE: assert property (done_o && ce_i |=> !done_o)
    else $error("verdict pulse longer than one cycle");
  AST_UNCHECKED: assert property (take && !pas |-> ##[2:4]
    (done_o && !checked_o && !fault_o)) else $error("unchecked request");
  AST_ROOT_TYPE: assert property (take && pas && !root_table_type_i
    |-> ##[2:4] (done_o && fault_reason_o == FR_ROOT_TYPE &&
    cpl_status_o == CPL_UR)) else $error("root type verdict wrong");
  AST_ROOT_FETCH: assert property (take && pas && root_table_type_i &&
    root_fetch_err_i |-> ##[2:4] (done_o && fault_reason_o == FR_ROOT_FETCH
    && cpl_status_o == CPL_CA)) else $error("root fetch verdict wrong");
  AST_UR: assert property (done_o && fault_o && fault_reason_o inside
    {8'h01, 8'h02, 8'h0d, 8'h10, 8'h11, 8'h19, 8'h1a, 8'h1b}
    |-> cpl_status_o == CPL_UR) else $error("blocking not UR");
  AST_CA: assert property (done_o && fault_o && fault_reason_o inside
    {8'h03, 8'h07, 8'h08} |-> cpl_status_o == CPL_CA)
    else $error("error not CA");
  AST_QUAL: assert property (done_o && fault_o |-> qualified_o ==
    !(fault_reason_o inside {8'h01, 8'h02, 8'h1b}))
    else $error("qualified flag wrong");
  AST_CLEAN: assert property (done_o && !fault_o |->
    fault_reason_o == FR_NONE && cpl_status_o == CPL_SUCCESS)
    else $error("pass verdict carries a reason");
  AST_HOLD: assert property (!done_o |-> $stable(fault_o) &&
    $stable(fault_reason_o)) else $error("verdict moved without done");
  // main outcomes seen at least once
  cover property (done_o && !fault_o && checked_o);
  cover property (done_o && cpl_status_o == CPL_UR);
  cover property (done_o && cpl_status_o == CPL_CA);
endmodule : pftc_checker_sva
bind pftc_checker pftc_checker_sva u_sva (.*);

/* pftc_endpoint.sv */
// endpoint model issuing translation requests
`timescale 1ns/1ps
module pftc_endpoint (
  input  wire logic        clk_i,
  input  wire logic        go_i,   // launch one request
  input  wire logic        done_i, // verdict pulse from the checker
  input  wire logic [24:0] req_i,  // at, pasid flag, exec, super, pasid
  output logic             valid_o,
  output logic [24:0]      req_o
);
  initial valid_o = 1'b0;
  initial req_o = '0;
  // held from launch to verdict, then released
  always @(negedge clk_i) begin
    if (valid_o && done_i) begin
      valid_o <= 1'b0;
      req_o   <= ~req_o; // released lines never keep a stale value
    end else if (go_i && !valid_o) begin
      valid_o <= 1'b1;
      req_o   <= req_i;
    end
  end
endmodule : pftc_endpoint

/* tb_top.sv */
// self-checking bench for the pasid translation fault checker
`timescale 1ns/1ps
module tb_top;
  import pftc_pkg::*;
  logic clk_i, rstn_i, go, v, ready, done_o, checked_o, fault_o, qual_o;
  logic at_hp, hp, xb, sb, hsel, root_table_type, rfe, hv, lv, cp, pte, xen, nst;
  logic tov, tfe, tp, sen, supervisor_enable, sle;
  logic [1:0]          at;
  logic [2:0]          tt, gw, ts, st_o;
  logic [7:0]          reason_o;
  logic [PASID_W-1:0]  pid;
  logic [24:0]         rq;       // request as the endpoint holds it
  logic [13:0]         expq[$];  // checked, fault, reason, qual, status
  int                  num_errors, checks_done, cyc, seed;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  pftc_endpoint ep (.clk_i(clk_i), .go_i(go), .done_i(done_o),
    .req_i({at, hp, xb, sb, pid}), .valid_o(v), .req_o(rq));
  pftc_checker uut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .req_valid_i(v), .req_ready_o(ready), .req_at_i(rq[24:23]),
    .req_has_pasid_i(rq[22]), .req_pasid_i(rq[19:0]),
    .exec_ask_bit_i(rq[21]), .supervisor_level_flag_i(rq[20]),
    .root_table_type_i(root_table_type), .root_fetch_err_i(rfe),
    .root_half_sel_i(hsel), .high_half_valid_i(hv), .low_half_valid_i(lv),
    .ctx_present_i(cp), .ctx_ttype_i(tt), .guest_width_field_i(gw),
    .process_tag_enable_i(pte), .tag_table_size_i(ts),
    .exec_ask_enable_i(xen), .ctx_nested_i(nst), .tag_addr_over_i(tov),
    .tag_fetch_err_i(tfe), .tag_entry_present_i(tp),
    .supervisor_enable_i(sen), .sl_root_fetch_err_i(supervisor_enable),
    .sl_lower_fetch_err_i(sle), .done_o(done_o), .checked_o(checked_o),
    .fault_o(fault_o), .fault_reason_o(reason_o), .qualified_o(qual_o),
    .cpl_status_o(st_o));

  // a clean request with random size, pasid, type and half
  task automatic set_good;
    {at, hp, xb, sb} = 5'b01111;
    {root_table_type, rfe, hv, lv, cp, pte, xen} = 7'b1011111;
    {nst, tov, tfe, tp, sen, supervisor_enable, sle} = 7'b1001100;
    hsel = 1'($random(seed));
    tt = ($random(seed) % 2) ? 3'h7 : 3'h5;
    gw = 3'h2;
    ts = 3'($random(seed));
    pid = PASID_W'($random(seed)) & ((20'h1 << (ts + 5)) - 20'h1);
  endtask : set_good

  task automatic good;
    @(negedge clk_i);
    set_good();
  endtask : good

  // note the verdict the rules call for, then launch and wait
  task automatic run(input string nm, input logic [7:0] r);
    logic [2:0] st;
    int         n;
    st = (r == FR_NONE) ? CPL_SUCCESS :
         (r inside {8'h03, 8'h07, 8'h08}) ? CPL_CA : CPL_UR;
    expq.push_back({at == AT_TRANSLATION && hp, r != FR_NONE, r,
      r != FR_NONE && !(r inside {8'h01, 8'h02, 8'h1b}), st});
    go <= 1'b1;
    @(negedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (busy_check() && n < 20);
    if (n >= 20) num_errors++;
    $display("test %s done", nm);
  endtask : run

  function automatic bit busy_check;
    return v !== 1'b0;
  endfunction : busy_check

  // compare each verdict pulse against the oldest note
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      checks_done++;
      if (expq.size() == 0 ||
          {checked_o, fault_o, reason_o, qual_o, st_o} !== expq[0]) begin
        num_errors++;
        $display("ERROR verdict exp %h got %h",
          expq.size() ? expq[0] : 14'h0,
          {checked_o, fault_o, reason_o, qual_o, st_o});
      end
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    seed = 300;
    go = 1'b0;
    rstn_i = 1'b0;
    set_good();
    repeat (2) @(negedge clk_i);
    checks_done++;
    if (ready !== 1'b1 || done_o !== 1'b0 || fault_o !== 1'b0) begin
      num_errors++;
      $display("ERROR reset outputs exp 100 got %b%b%b", ready, done_o, fault_o);
    end
    rstn_i = 1'b1;
    good(); run("pass", FR_NONE);
    good(); at = 2'h2; run("untranslated", FR_NONE);
    good(); hp = 1'b0; run("no pasid", FR_NONE);
    good(); root_table_type = 1'b0; rfe = 1'b1; run("root type", FR_ROOT_TYPE);
    good(); rfe = 1'b1; hv = 1'b0; run("root fetch", FR_ROOT_FETCH);
    for (int h = 0; h < 2; h++) begin
      good();
      hsel = h[0];
      {hv, lv} = h[0] ? 2'b01 : 2'b10;
      run("half", FR_ROOT_ABSENT);
    end
    good(); cp = 1'b0; pte = 1'b0; run("ctx absent", FR_CTX_ABSENT);
    for (int t = 0; t < 8; t++) begin
      good();
      tt = t[2:0];
      gw = 3'h5;
      run("ttype", t inside {1, 5, 7} ? FR_CTX_PROGRAM : FR_TT_BLOCK);
    end
    good(); pte = 1'b0; xen = 1'b0; run("tag off", FR_TAG_DISABLED);
    for (int s = 0; s < 8; s += 7) for (int o = 0; o < 2; o++) begin
      good();
      ts = s[2:0];
      xen = 1'b0;
      pid = (20'h1 << (s + 5)) - 20'h1 + 20'(o);
      run("size", o ? FR_TAG_RANGE : FR_EXEC_DENIED);
    end
    good(); tov = 1'b1; sen = 1'b0; run("tag addr", FR_CTX_PROGRAM);
    good(); tfe = 1'b1; run("tag err", FR_CTX_PROGRAM);
    good(); sen = 1'b0; run("super", FR_SUPER_DENIED);
    good(); sen = 1'b0; tp = 1'b0; run("no entry", FR_NONE);
    good(); supervisor_enable = 1'b1; sle = 1'b1; run("nested", FR_CTX_PROGRAM);
    good(); nst = 1'b0; supervisor_enable = 1'b1; run("flat", FR_NONE);
    good(); sle = 1'b1; run("lower", FR_SL_FETCH);
    @(negedge clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (20) begin
      good();
      run("random", FR_NONE);
    end
    repeat (3) @(negedge clk_i);
    checks_done++;
    if (expq.size() != 0) begin
      num_errors++;
      $display("ERROR pending verdicts exp 0 got %0d", expq.size());
    end
    end_of_test();
  end
endmodule : tb_top
